// file: logic/dhpm_device.sv
// Purpose: Device end of the host port: pin function mux and decoding
// Assumes: Register file answers reg_rdata combinationally from reg_addr
// Notes: All port levels pass two flip-flops before any logic reads them
//
// Contract
// - Function selects choose the port configuration
// - Modulation use takes lines as keying data
// - Parallel: lines 15..8 are address 7..0
// - Serial: resync line resets serial state
// - Serial: line 3 drives readback data
// - Line 2: serial data, or write strobe
// - Line 1: serial clock, or read strobe
// - Line 0: chip select, or width select
// - Modulation word split by function selects

`timescale 1ns/100ps

module dhpm_device (
    input wire logic clk_sys,
    input wire logic arst_n,
    dhpm_port_if.dev port,
    output logic reg_wr_stb,
    output logic reg_rd_stb,
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wide,
    input wire logic [15:0] reg_rdata,
    output dhpm_pkg::dhpm_mode_t port_mode,
    output logic mod_valid,
    output dhpm_pkg::dhpm_mod_t mod_word
);
    import dhpm_pkg::*;

    // Serial frame phases, Gray along the path
    typedef enum logic [1:0] {
        SP_INSTR = 2'b00,
        SP_DATA = 2'b01,
        SP_DONE = 2'b11
    } dhpm_sphase_t;

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [31:0] line_s1_q;     // First stage, read by second only
    logic [31:0] line_s2_q;     // Safe copy of the port
    logic [31:0] line_p_q;      // Previous safe copy, for edges
    logic [3:0] fsel_s1_q;      // First stage of function selects
    logic [3:0] fsel_s2_q;      // Safe function selects

    // Two flops on every port input
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            line_s1_q <= 32'h0000_0000;
            line_s2_q <= 32'h0000_0000;
            line_p_q <= 32'h0000_0000;
            fsel_s1_q <= 4'h0;
            fsel_s2_q <= 4'h0;
        end else begin
            line_s1_q <= port.line;
            line_s2_q <= line_s1_q;
            line_p_q <= line_s2_q;
            fsel_s1_q <= port.fsel;
            fsel_s2_q <= fsel_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Mode decode and line roles
    dhpm_mode_t mode;
    assign mode = dhpm_mode(fsel_s2_q);
    wire is_ser = (mode == DHPM_SERIAL);
    wire is_par = (mode == DHPM_PARALLEL);
    wire is_mod = (mode == DHPM_MODULATION);
    // Serial roles
    wire cs_n = line_s2_q[LN_WIDTH];
    wire resync = is_ser & line_s2_q[LN_RESYNC];
    wire sclk_rise = is_ser & line_s2_q[LN_SCLK] & ~line_p_q[LN_SCLK];
    wire sclk_fall = is_ser & ~line_s2_q[LN_SCLK] & line_p_q[LN_SCLK];
    wire sdi = line_s2_q[LN_SDIO];
    wire ser_hold = resync | cs_n;
    // Parallel roles
    wire wr_rise = is_par & line_s2_q[LN_SDIO] & ~line_p_q[LN_SDIO];
    wire rd_level = is_par & line_s2_q[LN_SCLK];
    wire rd_rise = rd_level & ~line_p_q[LN_SCLK];
    wire par_wide = line_s2_q[LN_WIDTH];
    wire [7:0] par_addr = line_s2_q[ADDR_LO +: 8];
    wire [15:0] par_data = par_wide ? line_s2_q[DATA_LO +: 16]
                                    : {8'h00, line_s2_q[DATA_LO +: 8]};

    ////////////////////////////////////////////////////////////////////
    // Serial port state
    dhpm_sphase_t sph_q;        // Frame phase
    logic [2:0] bit_q;          // Bit within the current byte
    logic [7:0] sh_q;           // Shift register, in and out
    logic ser_rd_q;             // Frame is a readback
    logic sdo_q;                // Readback bit on line 3
    logic sdo_oe_q;             // Line 3 driven
    logic ser_wr_q;             // Serial write request pulse
    logic ser_ard_q;            // Serial read address pulse
    logic [7:0] ser_addr_q;     // Serial register address

    // Shift in on rising clock, shift readback out on falling clock
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sph_q <= SP_INSTR;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            ser_rd_q <= 1'b0;
            sdo_q <= 1'b0;
            sdo_oe_q <= 1'b0;
            ser_wr_q <= 1'b0;
            ser_ard_q <= 1'b0;
            ser_addr_q <= 8'h00;
        end else begin
            ser_wr_q <= 1'b0;
            ser_ard_q <= 1'b0;
            if (!is_ser || ser_hold) begin
                // Resync or deselect drops any partial frame
                sph_q <= SP_INSTR;
                bit_q <= 3'h0;
                ser_rd_q <= 1'b0;
                sdo_oe_q <= 1'b0;
            end else if (sclk_rise) begin
                bit_q <= bit_q + 3'h1;
                unique case (sph_q)
                    SP_INSTR: begin
                        sh_q <= {sh_q[6:0], sdi};
                        if (bit_q == 3'h7) begin
                            // MSB is read flag, low seven the address
                            sph_q <= SP_DATA;
                            ser_rd_q <= sh_q[6];
                            ser_ard_q <= sh_q[6];
                            ser_addr_q <= {1'b0, sh_q[5:0], sdi};
                        end
                    end
                    SP_DATA: begin
                        if (!ser_rd_q) begin
                            sh_q <= {sh_q[6:0], sdi};
                        end
                        if (bit_q == 3'h7) begin
                            sph_q <= SP_DONE;
                            ser_wr_q <= ~ser_rd_q;
                        end
                    end
                    SP_DONE: begin
                        // Extra clocks are ignored until deselect
                        bit_q <= bit_q;
                    end
                endcase
            end else if (sclk_fall && ser_rd_q && sph_q == SP_DATA) begin
                // First fall of the data byte loads the readback value
                sdo_oe_q <= 1'b1;
                if (bit_q == 3'h0) begin
                    sdo_q <= reg_rdata[7];
                    sh_q <= {reg_rdata[6:0], 1'b0};
                end else begin
                    sdo_q <= sh_q[7];
                    sh_q <= {sh_q[6:0], 1'b0};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register side requests, from either programming interface
    logic wr_stb_q;             // Write pulse
    logic rd_stb_q;             // Read pulse
    logic [7:0] addr_q;         // Register address
    logic [15:0] wdata_q;       // Write data
    logic wide_q;               // 16-bit transfer
    logic [15:0] rd_data_q;     // Parallel read data held on the port
    logic rd_oe_q;              // Parallel read drive

    // Parallel strobes are edge taken; serial requests pass through
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wr_stb_q <= 1'b0;
            rd_stb_q <= 1'b0;
            addr_q <= 8'h00;
            wdata_q <= 16'h0000;
            wide_q <= 1'b0;
            rd_data_q <= 16'h0000;
            rd_oe_q <= 1'b0;
        end else begin
            wr_stb_q <= wr_rise | ser_wr_q;
            rd_stb_q <= rd_rise | ser_ard_q;
            if (wr_rise || rd_rise) begin
                addr_q <= par_addr;
                wide_q <= par_wide;
            end else if (ser_ard_q || ser_wr_q) begin
                addr_q <= ser_addr_q;
                wide_q <= 1'b0;
            end
            if (wr_rise) begin
                wdata_q <= par_data;
            end else if (ser_wr_q) begin
                wdata_q <= {8'h00, sh_q};
            end
            // Read data follows the register while the strobe is high
            rd_oe_q <= rd_level & ~rd_rise;
            rd_data_q <= wide_q ? reg_rdata : {8'h00, reg_rdata[7:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Modulation capture
    logic mod_valid_q;          // Port word is modulation data
    dhpm_mod_t mod_q;           // Split modulation fields

    // All 32 lines, 4..0 included, count as data for codes 2 and 5
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mod_valid_q <= 1'b0;
            mod_q <= '0;
        end else begin
            mod_valid_q <= is_mod;
            if (is_mod) begin
                mod_q <= dhpm_split(fsel_s2_q, line_s2_q);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Port drive: readback on line 3, or read data on lines 31..16
    wire [15:0] rd_en = wide_q ? 16'hFFFF : 16'h00FF;
    assign port.dev_o = {rd_data_q, 12'h000, sdo_q, 3'h0};
    assign port.dev_oe = {rd_oe_q ? rd_en : 16'h0000,
                          12'h000, sdo_oe_q & is_ser, 3'h0};

    // User side outputs
    assign reg_wr_stb = wr_stb_q;
    assign reg_rd_stb = rd_stb_q;
    assign reg_addr = addr_q;
    assign reg_wdata = wdata_q;
    assign reg_wide = wide_q;
    assign port_mode = mode;
    assign mod_valid = mod_valid_q;
    assign mod_word = mod_q;
endmodule

// file: logic/dhpm_pkg.sv
// Purpose: Shared constants and helpers for the host port pin mux
// Assumes: 50 MHz clk_sys on both ends of the port
// Notes: Line positions, mode codes and strobe timing live here

package dhpm_pkg;
    // Port geometry
    localparam int PORT_W = 32;
    localparam int LN_WIDTH = 0;    // Chip select or width select
    localparam int LN_SCLK = 1;     // Serial clock or read strobe
    localparam int LN_SDIO = 2;     // Serial data or write strobe
    localparam int LN_SDO = 3;      // Serial readback output
    localparam int LN_RESYNC = 4;   // Serial port resync
    localparam int ADDR_LO = 8;     // Address on lines 15..8
    localparam int DATA_LO = 16;    // Register data on lines 31..16
    // Function select codes; every other code is modulation use
    localparam logic [3:0] FSEL_SERIAL = 4'h0;
    localparam logic [3:0] FSEL_PARALLEL = 4'h1;
    // Serial frame: instruction byte then data byte, MSB first
    localparam int SER_BITS = 16;
    localparam int SER_INSTR_BITS = 8;
    // Timing, in nanoseconds and derived cycles (least times round up)
    localparam int CLK_NS = 20;
    localparam int STROBE_NS = 160;
    localparam int READ_NS = 240;
    localparam int SCLK_HALF_NS = 200;
    localparam int RESYNC_NS = 100;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int READ_CYC = (READ_NS + CLK_NS - 1) / CLK_NS;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int RESYNC_CYC = (RESYNC_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        DHPM_SERIAL = 2'h0,
        DHPM_PARALLEL = 2'h1,
        DHPM_MODULATION = 2'h3
    } dhpm_mode_t;

    // Modulation fields split out of the port word
    typedef struct packed {
        logic freq_en;
        logic phase_en;
        logic amp_en;
        logic [31:0] freq;
        logic [15:0] phase;
        logic [11:0] amp;
    } dhpm_mod_t;

    // Port use from the function select levels
    function automatic dhpm_mode_t dhpm_mode(input logic [3:0] f);
        if (f == FSEL_SERIAL) begin
            return DHPM_SERIAL;
        end else if (f == FSEL_PARALLEL) begin
            return DHPM_PARALLEL;
        end
        return DHPM_MODULATION;
    endfunction

    // Partition of the 32-bit word by function select code
    function automatic dhpm_mod_t dhpm_split(input logic [3:0] f,
                                             input logic [31:0] w);
        dhpm_mod_t m;
        m = '0;
        case (f)
            4'h2: begin
                m.freq_en = 1'b1;
                m.freq = w;
            end
            4'h3: begin
                m.phase_en = 1'b1;
                m.phase = w[31:16];
            end
            4'h4: begin
                m.amp_en = 1'b1;
                m.amp = w[31:20];
            end
            4'h5: begin
                m.freq_en = 1'b1;
                m.phase_en = 1'b1;
                m.freq = {w[31:16], 16'h0000};
                m.phase = w[15:0];
            end
            4'h6: begin
                m.phase_en = 1'b1;
                m.amp_en = 1'b1;
                m.phase = w[31:16];
                m.amp = w[15:4];
            end
            default: begin
                m.freq_en = 1'b1;
                m.amp_en = 1'b1;
                m.freq = {w[31:16], 16'h0000};
                m.amp = w[15:4];
            end
        endcase
        return m;
    endfunction
endpackage

// file: logic/dhpm_port_if.sv
// Purpose: The 32 port lines and four function selects between ends
// Assumes: Both ends run on the same clk_sys
// Notes: A line neither end drives reads low

`timescale 1ns/100ps

interface dhpm_port_if;
    logic [3:0] fsel;       // Function select levels, host driven
    logic [31:0] host_o;    // Host drive values
    logic [31:0] host_oe;   // Host drive enables
    logic [31:0] dev_o;     // Device drive values
    logic [31:0] dev_oe;    // Device drive enables
    logic [31:0] line;      // Resolved level of each line

    // Wired resolution; host wins a clash
    assign line = (host_oe & host_o) | (~host_oe & dev_oe & dev_o);

    modport dev(input fsel, input line, output dev_o, output dev_oe);
    modport host(output fsel, output host_o, output host_oe, input line);
endinterface

// file: logic/dhpm_host.sv
// Purpose: Host end of the port: drives selects, strobes and frames
// Assumes: Device samples the port through two flops on clk_sys
// Notes: One command at a time; mode changes only while idle

`timescale 1ns/100ps

module dhpm_host (
    input wire logic clk_sys,
    input wire logic arst_n,
    dhpm_port_if.host port,
    input wire logic [3:0] mode_sel,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_read,
    input wire logic [7:0] cmd_addr,
    input wire logic [15:0] cmd_wdata,
    input wire logic cmd_wide,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    input wire logic [31:0] mod_data
);
    import dhpm_pkg::*;

    // Sequencer states, Gray from SETUP to HOLD and from RESYNC to DONE
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_SETUP = 3'b001,
        H_STROBE = 3'b011,
        H_HOLD = 3'b010,
        H_RESYNC = 3'b110,
        H_SHIFT = 3'b111,
        H_DONE = 3'b101
    } dhpm_hstate_t;

    ////////////////////////////////////////////////////////////////////
    // Device drive comes back through two flops
    logic [31:0] in_s1_q;       // First stage, read by second only
    logic [31:0] in_s2_q;       // Safe copy of the port

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            in_s1_q <= 32'h0000_0000;
            in_s2_q <= 32'h0000_0000;
        end else begin
            in_s1_q <= port.line;
            in_s2_q <= in_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    dhpm_hstate_t st_q;         // Sequencer state
    logic [3:0] fsel_q;         // Function select drive
    logic [7:0] tmr_q;          // Phase timer
    logic [4:0] bit_q;          // Serial bit count
    logic [15:0] tx_q;          // Serial frame out
    logic [15:0] rx_q;          // Read data in
    logic rd_q;                 // Command is a read
    logic wide_q;               // Command width
    logic [31:0] o_q;           // Line values
    logic [31:0] oe_q;          // Line enables
    logic rsp_q;                // Answer pulse

    dhpm_mode_t mode;
    assign mode = dhpm_mode(fsel_q);
    wire take = (st_q == H_IDLE) & cmd_valid & (mode != DHPM_MODULATION);
    wire tmr_end = (tmr_q == 8'h00);
    wire sclk = o_q[LN_SCLK];
    // Host lets go of line 2 once readback bits are due
    wire sdio_free = rd_q & (bit_q >= 5'(SER_INSTR_BITS));
    wire [15:0] par_en = wide_q ? 16'hFFFF : 16'h00FF;

    // One process sequences both programming interfaces
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= H_IDLE;
            fsel_q <= FSEL_SERIAL;
            tmr_q <= 8'h00;
            bit_q <= 5'h00;
            tx_q <= 16'h0000;
            rx_q <= 16'h0000;
            rd_q <= 1'b0;
            wide_q <= 1'b0;
            o_q <= 32'h0000_0001;
            oe_q <= 32'h0000_0001;
            rsp_q <= 1'b0;
        end else begin
            rsp_q <= 1'b0;
            if (!tmr_end) begin
                tmr_q <= tmr_q - 8'h01;
            end
            unique case (st_q)
                H_IDLE: begin
                    fsel_q <= mode_sel;
                    if (mode == DHPM_MODULATION) begin
                        o_q <= mod_data;
                        oe_q <= 32'hFFFF_FFFF;
                    end else if (mode == DHPM_SERIAL) begin
                        o_q <= 32'h0000_0001;
                        oe_q <= 32'h0000_0017;
                    end else begin
                        o_q <= {16'h0000, 15'h0000, wide_q};
                        oe_q <= 32'h0000_0007;
                    end
                    if (take) begin
                        rd_q <= cmd_read;
                        wide_q <= cmd_wide & (mode == DHPM_PARALLEL);
                        tx_q <= {cmd_read, cmd_addr[6:0], cmd_wdata[7:0]};
                        if (mode == DHPM_SERIAL) begin
                            st_q <= H_RESYNC;
                            o_q <= 32'h0000_0011;
                            tmr_q <= 8'(RESYNC_CYC);
                        end else begin
                            st_q <= H_SETUP;
                            o_q <= {cmd_wdata, cmd_addr, 7'h00, cmd_wide};
                            oe_q <= {cmd_read ? 16'h0000 : 16'hFFFF,
                                     16'hFF07};
                            tmr_q <= 8'(STROBE_CYC);
                        end
                    end
                end
                H_SETUP: begin
                    if (tmr_end) begin
                        st_q <= H_STROBE;
                        // Read strobe on line 1, write strobe on line 2
                        o_q[LN_SCLK] <= rd_q;
                        o_q[LN_SDIO] <= ~rd_q;
                        tmr_q <= 8'(rd_q ? READ_CYC : STROBE_CYC);
                    end
                end
                H_STROBE: begin
                    if (tmr_end) begin
                        st_q <= H_HOLD;
                        rx_q <= in_s2_q[DATA_LO +: 16] &
                                (rd_q ? par_en : 16'h0000);
                        o_q[LN_SCLK] <= 1'b0;
                        o_q[LN_SDIO] <= 1'b0;
                        tmr_q <= 8'(STROBE_CYC);
                    end
                end
                H_HOLD: begin
                    if (tmr_end) begin
                        st_q <= H_DONE;
                    end
                end
                H_RESYNC: begin
                    if (tmr_end) begin
                        // Resync ends, select device, first bit out
                        st_q <= H_SHIFT;
                        o_q <= {29'h0, tx_q[15], 2'b00};
                        tx_q <= {tx_q[14:0], 1'b0};
                        bit_q <= 5'h00;
                        tmr_q <= 8'(SCLK_HALF_CYC);
                    end
                end
                H_SHIFT: begin
                    if (tmr_end) begin
                        tmr_q <= 8'(SCLK_HALF_CYC);
                        if (!sclk) begin
                            o_q[LN_SCLK] <= 1'b1;
                            if (sdio_free) begin
                                rx_q <= {rx_q[14:0], in_s2_q[LN_SDO]};
                            end
                            bit_q <= bit_q + 5'h01;
                        end else if (bit_q == 5'(SER_BITS)) begin
                            st_q <= H_DONE;
                            o_q <= 32'h0000_0001;
                        end else begin
                            o_q[LN_SCLK] <= 1'b0;
                            o_q[LN_SDIO] <= tx_q[15];
                            tx_q <= {tx_q[14:0], 1'b0};
                        end
                    end
                    oe_q[LN_SDIO] <= ~sdio_free;
                end
                H_DONE: begin
                    st_q <= H_IDLE;
                    rsp_q <= 1'b1;
                    oe_q[LN_SDIO] <= 1'b1;
                    if (!rd_q) begin
                        rx_q <= 16'h0000;
                    end
                end
                default: begin
                    st_q <= H_IDLE;
                end
            endcase
        end
    end

    assign port.fsel = fsel_q;
    assign port.host_o = o_q;
    assign port.host_oe = oe_q;
    assign cmd_ready = (st_q == H_IDLE) & (mode != DHPM_MODULATION);
    assign rsp_valid = rsp_q;
    assign rsp_rdata = rx_q;
endmodule

// file: sim/dhpm_checker.sv
// Purpose: Wire-level checks on the host port between both ends
// Assumes: Host and device share clk_sys
// Notes: Mode checks wait for fsel to settle past the sync flops
`timescale 1ns/100ps
module dhpm_checker (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [3:0] fsel,
    input wire logic [31:0] host_o,
    input wire logic [31:0] host_oe,
    input wire logic [31:0] dev_o,
    input wire logic [31:0] dev_oe,
    input wire logic [31:0] line
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////
    // Leaving serial use only with the chip deselected
    property p_sel; $changed(fsel) && $past(fsel) == 4'h0 |-> $past(line[0]);
    endproperty
    a_sel: assert property (p_sel) else $error("mode left mid frame");
    // Settled modulation: host owns every line, device is silent
    property p_mod; $stable(fsel)[*4] ##0 fsel > 4'h1
        |-> dev_oe == 32'h0 && host_oe == 32'hFFFFFFFF; endproperty
    a_mod: assert property (p_mod) else $error("mod drive wrong");
    // Address lines 15..8 driven by the host during a write strobe
    property p_adr; fsel == 4'h1 && line[2] |-> host_oe[15:8] == 8'hFF;
    endproperty
    a_adr: assert property (p_adr) else $error("no address");
    // Resync only with the chip deselected
    property p_rsy; fsel == 4'h0 && line[4] |-> line[0]; endproperty
    a_rsy: assert property (p_rsy) else $error("resync with cs");
    // Settled serial: device drives the readback line alone
    property p_sdo; $stable(fsel)[*4] ##0 fsel == 4'h0
        |-> (dev_oe & 32'hFFFFFFF7) == 32'h0; endproperty
    a_sdo: assert property (p_sdo) else $error("stray drive");
    // Write strobe stands nine cycles: rounded-up count plus load edge
    property p_wr; $rose(line[2]) && fsel == 4'h1
        |-> line[2][*8] ##1 line[2] ##1 !line[2]; endproperty
    a_wr: assert property (p_wr) else $error("write strobe width");
    // Read strobe stands thirteen cycles, for the same reason
    property p_rd; $rose(line[1]) && fsel == 4'h1
        |-> ##12 line[1] ##1 !line[1]; endproperty
    a_rd: assert property (p_rd) else $error("read strobe width");
    // Width select holds while the write strobe is up
    property p_wid; fsel == 4'h1 && line[2] && $past(line[2])
        |-> $stable(line[0]); endproperty
    a_wid: assert property (p_wid) else $error("width moved");
endmodule

// file: sim/dhpm_tb.sv
// Purpose: Both port ends joined, driven through host commands
// Assumes: Register file answers {addr, ~addr}
// Notes: Serial data is one byte, so only the low byte is compared
`timescale 1ns/100ps
module dhpm_tb;
    import dhpm_pkg::*;
    logic clk_sys = 1'b0, arst_n = 1'b0;
    logic cmd_valid = 1'b0, cmd_ready, cmd_read = 1'b0, cmd_wide = 1'b0;
    logic [3:0] mode_sel = 4'h0;
    logic [7:0] cmd_addr = 8'h00, reg_addr, wa, ra;
    logic [15:0] cmd_wdata = 16'h0000, reg_wdata, reg_rdata, rsp_rdata, wd;
    logic [31:0] mod_data = 32'hA5C31E0F;
    logic reg_wr_stb, reg_rd_stb, reg_wide, rsp_valid, mod_valid, ww;
    dhpm_mode_t port_mode;
    dhpm_mod_t mod_word;
    int mismatches = 0, n_checks = 0;
    dhpm_port_if port_if();
    dhpm_device i_dhpm_device (.clk_sys(clk_sys), .arst_n(arst_n),
        .port(port_if), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wide(reg_wide),
        .reg_rdata(reg_rdata), .port_mode(port_mode),
        .mod_valid(mod_valid), .mod_word(mod_word));
    dhpm_host i_dhpm_host (.clk_sys(clk_sys), .arst_n(arst_n),
        .port(port_if), .mode_sel(mode_sel), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_wide(cmd_wide), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .mod_data(mod_data));
    dhpm_checker i_chk (.clk_sys(clk_sys), .arst_n(arst_n),
        .fsel(port_if.fsel), .host_o(port_if.host_o),
        .host_oe(port_if.host_oe), .dev_o(port_if.dev_o),
        .dev_oe(port_if.dev_oe), .line(port_if.line));
    ////////////////////////////////////////////////////////////////////
    // 50 MHz clock; register file reads combinationally
    always #10 clk_sys = ~clk_sys;
    assign reg_rdata = {reg_addr, ~reg_addr};
    // Latch each register write for later comparison
    always @(posedge clk_sys) begin
        if (reg_wr_stb) begin
            wa <= reg_addr;
            wd <= reg_wdata;
            ww <= reg_wide;
        end
        // Address of the last register read request
        if (reg_rd_stb) begin
            ra <= reg_addr;
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // One host command, offered until taken, then wait for the answer
    task automatic cmd(input logic rd, input logic [7:0] a,
                       input logic [15:0] d, input logic w);
        int n;
        {cmd_read, cmd_addr, cmd_wdata, cmd_wide} = {rd, a, d, w};
        cmd_valid = 1'b1;
        for (n = 0; n < 50 && cmd_ready !== 1'b1; n++) @(posedge clk_sys) #1;
        @(posedge clk_sys) #1;
        cmd_valid = 1'b0;
        for (n = 0; n < 900 && rsp_valid !== 1'b1; n++) @(posedge clk_sys) #1;
        chk(rsp_valid, 1'b1);
    endtask
    // Mode changes only while idle; allow the sync flops to catch up
    task automatic set_mode(input logic [3:0] m);
        mode_sel = m;
        repeat (8) @(posedge clk_sys) #1;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        mismatches++;
        finish_test();
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        #1 arst_n = 1'b1;
        set_mode(FSEL_SERIAL);
        chk(port_mode, DHPM_SERIAL);
        cmd(1'b0, 8'hC5, 16'h00A7, 1'b0);
        chk({wa[6:0], wd[7:0], ww}, {7'h45, 8'hA7, 1'b0});
        cmd(1'b1, 8'h12, 16'h0000, 1'b0);
        chk({ra, rsp_rdata[7:0]}, {8'h12, 8'hED});
        set_mode(FSEL_PARALLEL);
        cmd(1'b0, 8'h3C, 16'hBEEF, 1'b1);
        chk({wa, wd, ww}, {8'h3C, 16'hBEEF, 1'b1});
        cmd(1'b0, 8'hF0, 16'h005A, 1'b0);
        chk({wa, wd[7:0], ww}, {8'hF0, 8'h5A, 1'b0});
        cmd(1'b1, 8'h81, 16'h0000, 1'b1);
        chk({ra, rsp_rdata}, {8'h81, 16'h817E});
        set_mode(4'h2);
        chk({port_mode, mod_valid, cmd_ready}, {DHPM_MODULATION, 2'b10});
        chk(mod_word.freq, 32'hA5C31E0F);
        set_mode(4'h6);
        chk({mod_word.phase_en, mod_word.amp_en}, 2'b11);
        chk({mod_word.phase, mod_word.amp}, {16'hA5C3, 12'h1E0});
        set_mode(4'h3);
        chk({mod_word.phase_en, mod_word.phase}, {1'b1, 16'hA5C3});
        set_mode(4'h4);
        chk({mod_word.amp_en, mod_word.amp}, {1'b1, 12'hA5C});
        set_mode(4'h5);
        chk({mod_word.freq[31:16], mod_word.phase}, 32'hA5C31E0F);
        set_mode(4'hF);
        chk({mod_word.freq[31:16], mod_word.amp}, 28'hA5C31E0);
        finish_test();
    end
endmodule
